// ==== transfer_table_skip_exec.sv ====
`timescale 1ns/1ps
module transfer_table_skip_exec (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [1:0] cpu_clock_divider_control,
   input wire logic op_valid,
   input wire exec_pkg::op_e op_code,
   input wire logic [1:0] op_len,
   input wire logic op_table_call,
   input wire logic op_skip_cond,
   input wire logic [2:0] op_reg,
   input wire logic [1:0] op_rp,
   input wire logic [7:0] op_imm,
   input wire logic [11:0] pc,
   input wire logic bank_select_enable,
   input wire logic [3:0] bank_number_register,
   input wire logic [7:0] ram_rdata,
   input wire logic [7:0] rom_data,
   output logic op_ready,
   output logic op_done,
   output logic skip_pending,
   output logic mc_tick,
   output logic ram_we,
   output logic ram_wide,
   output logic [11:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic [11:0] rom_addr,
   output logic [7:0] wide_accumulator,
   output logic [7:0] data_pointer_pair,
   output logic [7:0] table_offset_pair
);
   import exec_pkg::*;
   typedef enum logic [1:0] {st_idle, st_exec, st_skip} state_e;

   state_e state;
   logic [1:0] count;
   logic [3:0] regs [8];
   logic [3:0] next_regs [8];
   op_e cur_op;
   logic [2:0] cur_reg;
   logic [1:0] cur_rp;
   logic [7:0] cur_imm;
   logic cur_nop;
   logic cur_skc;
   logic cur_wr;
   logic [1:0] last_grp;

   cycle_tick_gen u_tick (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .cpu_clock_divider_control(cpu_clock_divider_control),
      .mc_tick(mc_tick)
   );

   wire last = state != st_idle && count == CYC_ONE;
   wire commit = mc_tick && state == st_exec && count == CYC_ONE;
   wire accept = mc_tick && op_valid && op_ready;
   wire [2:0] pair_hi = {cur_rp, 1'b0};
   wire [2:0] pair_lo = {cur_rp, 1'b1};
   wire skip_set = commit && !cur_nop &&
                   ((is_step_up(cur_op) && next_regs[R_L] == NIB_ZERO) ||
                    (is_step_down(cur_op) && next_regs[R_L] == NIB_FULL) ||
                    (cur_op == op_other && cur_skc));
   // a skip decided at a commit applies to the op taken on that same tick
   wire skipping = skip_pending || skip_set;
   wire [1:0] grp_new = grp_of(op_code, op_rp);
   wire string_nop = grp_new != GRP_NONE && grp_new == last_grp; // [RQ19]
   wire [1:0] skip_cost = (op_table_call || op_len != LEN_LONG) ?
                          SKIP_SHORT : SKIP_LONG; // [RQ2] [RQ3] [RQ4]

   assign op_ready = state == st_idle || last; // [RQ1]
   assign op_done = mc_tick && last;
   assign ram_we = commit && cur_wr && !cur_nop;
   assign wide_accumulator = {regs[R_X], regs[R_A]};
   assign data_pointer_pair = {regs[R_H], regs[R_L]};
   assign table_offset_pair = {regs[R_D], regs[R_E]};

   // addressing for the op being taken, seen through this tick's commit
   wire [7:0] hl_now = {next_regs[R_H], next_regs[R_L]};
   wire [7:0] xa_now = {next_regs[R_X], next_regs[R_A]};
   wire [7:0] de_now = {next_regs[R_D], next_regs[R_E]};
   wire [7:0] rpa_now = op_rp[0] ? {next_regs[R_D], next_regs[R_L]} : de_now;
   wire [3:0] bank_ptr = bank_select_enable ? bank_number_register
                                            : BANK0; // [RQ15]
   wire [3:0] bank_mem = bank_select_enable ? bank_number_register :
                         (op_imm[7] ? BANK15 : BANK0); // [RQ17]
   wire am_e cls = addr_class(op_code);
   wire [11:0] next_ram_addr = (cls == am_rpa) ? {BANK0, rpa_now} : // [RQ16]
                               (cls == am_mem) ? {bank_mem, op_imm} :
                               {bank_ptr, hl_now};
   // bits above the 12-bit rom space are dropped, so B must be zero [RQ14]
   wire [11:0] next_rom_addr =
      (op_code == op_rom_table_read_page_offset_form) ? {pc[11:8], de_now} : // [RQ10]
      (op_code == op_rom_table_read_page_accum_form) ? {pc[11:8], xa_now} : // [RQ11]
      (op_code == op_rom_table_read_four_nibble_pointer_form) ? {next_regs[R_C], de_now} : // [RQ12]
      {next_regs[R_C], xa_now}; // [RQ13]

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_regs[i] = regs[i];
      end
      if (commit && !cur_nop) begin
         case (cur_op)
            op_mov_a_imm: next_regs[R_A] = cur_imm[3:0];
            op_mov_reg_imm: next_regs[cur_reg] = cur_imm[3:0];
            op_mov_rp_imm: begin
               next_regs[pair_hi] = cur_imm[7:4];
               next_regs[pair_lo] = cur_imm[3:0];
            end
            op_ld_a_hl, op_ld_a_rpa, op_ld_a_mem, op_xch_a_hl, op_xch_a_rpa,
            op_xch_a_mem: next_regs[R_A] = ram_rdata[3:0];
            op_ld_a_hl_inc, op_xch_a_hl_inc: begin
               next_regs[R_A] = ram_rdata[3:0];
               next_regs[R_L] = regs[R_L] + 4'h1; // [RQ6] [RQ8]
            end
            op_ld_a_hl_dec, op_xch_a_hl_dec: begin
               next_regs[R_A] = ram_rdata[3:0];
               next_regs[R_L] = regs[R_L] - 4'h1; // [RQ7] [RQ9]
            end
            op_ld_xa_hl, op_ld_xa_mem, op_xch_xa_hl, op_xch_xa_mem: begin
               next_regs[R_X] = ram_rdata[7:4];
               next_regs[R_A] = ram_rdata[3:0];
            end
            op_rom_table_read_page_offset_form, op_rom_table_read_page_accum_form, op_rom_table_read_four_nibble_pointer_form, op_rom_table_read_four_nibble_accum_form: begin
               next_regs[R_X] = rom_data[7:4];
               next_regs[R_A] = rom_data[3:0];
            end
            op_mov_a_reg: next_regs[R_A] = regs[cur_reg];
            op_mov_reg_a: next_regs[cur_reg] = regs[R_A];
            op_xch_a_reg: begin
               next_regs[R_A] = regs[cur_reg];
               next_regs[cur_reg] = regs[R_A];
            end
            op_mov_xa_rp: begin
               next_regs[R_X] = regs[pair_hi];
               next_regs[R_A] = regs[pair_lo];
            end
            op_mov_rp_xa: begin
               next_regs[pair_hi] = regs[R_X];
               next_regs[pair_lo] = regs[R_A];
            end
            op_xch_xa_rp: begin
               next_regs[R_X] = regs[pair_hi];
               next_regs[R_A] = regs[pair_lo];
               next_regs[pair_hi] = regs[R_X];
               next_regs[pair_lo] = regs[R_A];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 8; i++) begin
            regs[i] <= REG_RESET;
         end
         skip_pending <= 1'b0;
      end else if (clk_en) begin
         for (int i = 0; i < 8; i++) begin
            regs[i] <= next_regs[i];
         end
         skip_pending <= skipping && !accept;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         count <= CYC_ONE;
      end else if (accept) begin
         state <= skipping ? st_skip : st_exec;
         count <= skipping ? skip_cost
                           : base_cycles(op_code, op_len); // [RQ18]
      end else if (mc_tick && state != st_idle) begin
         if (count == CYC_ONE) begin
            state <= st_idle;
         end else begin
            count <= count - 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cur_op <= op_other;
         cur_reg <= 3'h0;
         cur_rp <= 2'h0;
         cur_imm <= 8'h00;
         cur_nop <= 1'b0;
         cur_skc <= 1'b0;
         cur_wr <= 1'b0;
         last_grp <= GRP_NONE;
         ram_addr <= 12'h000;
         ram_wide <= 1'b0;
         ram_wdata <= 8'h00;
         rom_addr <= 12'h000;
      end else if (accept) begin
         cur_op <= op_code;
         cur_reg <= op_reg;
         cur_rp <= op_rp;
         cur_imm <= op_imm;
         cur_nop <= !skipping && string_nop; // [RQ19]
         cur_skc <= op_skip_cond;
         cur_wr <= !skipping && writes_ram(op_code);
         last_grp <= skipping ? GRP_NONE : grp_new;
         ram_addr <= next_ram_addr;
         ram_wide <= is_wide(op_code);
         ram_wdata <= {next_regs[R_X], next_regs[R_A]};
         rom_addr <= next_rom_addr;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_no_skip_cost;
      commit && cur_op == op_other && !cur_skc |=> !skip_pending;
   endproperty
   a_no_skip_cost: assert property (p_no_skip_cost) // [RQ1]
      else $error("false skip condition armed a skip");

   property p_skip_short;
      accept && skipping && op_len != 2'h3
         |=> state == st_skip && count == 2'h1;
   endproperty
   a_skip_short: assert property (p_skip_short) // [RQ2]
      else $error("short skip not one cycle");

   property p_skip_long;
      accept && skipping && op_len == 2'h3 && !op_table_call
         |=> state == st_skip && count == 2'h2;
   endproperty
   a_skip_long: assert property (p_skip_long) // [RQ3]
      else $error("long skip not two cycles");

   property p_skip_table_call;
      accept && skipping && op_table_call |=> count == 2'h1 && !ram_we;
   endproperty
   a_skip_table_call: assert property (p_skip_table_call) // [RQ4]
      else $error("table call skip not one cycle");

   property p_tick_rate;
      mc_tick && cpu_clock_divider_control != 2'h0 |=> !mc_tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) // [RQ5]
      else $error("machine cycle shorter than divider");

   property p_inc_load;
      commit && cur_op == op_ld_a_hl_inc
         |=> regs[R_L] == 4'($past(regs[R_L]) + 4'h1)
             && regs[R_A] == $past(ram_rdata[3:0]);
   endproperty
   a_inc_load: assert property (p_inc_load) // [RQ6]
      else $error("post increment load wrong");

   property p_dec_skip;
      commit && cur_op == op_ld_a_hl_dec && regs[R_L] == 4'h0 |-> skipping;
   endproperty
   a_dec_skip: assert property (p_dec_skip) // [RQ7]
      else $error("decrement wrap did not skip");

   property p_xch_write;
      accept && !skipping && op_code == op_xch_a_hl_inc
         |=> !ram_we ##1 ram_we && ram_wdata[3:0] == $past(regs[R_A], 2);
   endproperty
   a_xch_write: assert property (p_xch_write) // [RQ8]
      else $error("swap write wrong");

   property p_page_table;
      accept && !skipping && op_code == op_rom_table_read_page_offset_form
         |=> count == 2'h3 && rom_addr[11:8] == $past(pc[11:8]);
   endproperty
   a_page_table: assert property (p_page_table) // [RQ10]
      else $error("page table read wrong");

   property p_rpa_bank0;
      state == st_exec && cur_op == op_ld_a_rpa |-> ram_addr[11:8] == 4'h0;
   endproperty
   a_rpa_bank0: assert property (p_rpa_bank0) // [RQ16]
      else $error("restricted pointer not bank zero");

   property p_string_run;
      accept && !skipping && op_code == op_mov_rp_imm && op_rp == 2'h0
         && last_grp == 2'h1 |=> cur_nop;
   endproperty
   a_string_run: assert property (p_string_run) // [RQ19]
      else $error("string effect load executed");

   c_skip_long: cover property (accept && skipping && op_len == 2'h3);
   c_table_read: cover property (commit && is_table(cur_op));
   c_inc_wrap: cover property (skip_set && is_step_up(cur_op));
   c_string_nop: cover property (commit && cur_nop);
endmodule

// ==== exec_pkg.sv ====
// Contract
// RQ1: a skip-capable instruction that skips nothing costs no extra cycle
// RQ2: skipping a one or two byte instruction costs one extra cycle
// RQ3: skipping a three byte jump or call costs two extra cycles
// RQ4: the table call instruction is always skipped in one cycle
// RQ5: one machine cycle is one cpu clock, divider picks one of four rates
// RQ6: post-increment load: A gets (pointer), low nibble +1, skip on 0
// RQ7: post-decrement load: A gets (pointer), low nibble -1, skip on F
// RQ8: post-increment swap: A swaps (pointer), low nibble +1, skip on 0
// RQ9: post-decrement swap: A swaps (pointer), low nibble -1, skip on F
// RQ10: page-offset table read: pc[11:8] and offset pair, 3 cycles
// RQ11: page-accumulator table read: pc[11:8] and wide accumulator, 3 cycles
// RQ12: four-nibble pointer table read: BC and offset pair, 3 cycles
// RQ13: four-nibble accumulator table read: BC and wide accumulator, 3 cycles
// RQ14: software clears B before any four-nibble table read
// RQ15: pointer-pair data access uses bank enable gating bank number
// RQ16: restricted pointer forms always reach bank zero
// RQ17: direct operands, banking off: low half bank 0, high half bank 15
// RQ18: other moves take one cycle per encoded byte
// RQ19: repeated immediate loads of one string group run only the first
package exec_pkg;
   typedef enum logic [5:0] {
      op_other, op_mov_a_imm, op_mov_reg_imm, op_mov_rp_imm,
      op_ld_a_hl, op_ld_a_hl_inc, op_ld_a_hl_dec, op_ld_a_rpa,
      op_ld_xa_hl, op_st_hl_a, op_st_hl_xa, op_ld_a_mem, op_ld_xa_mem,
      op_st_mem_a, op_st_mem_xa, op_mov_a_reg, op_mov_xa_rp, op_mov_reg_a,
      op_mov_rp_xa, op_xch_a_hl, op_xch_a_hl_inc, op_xch_a_hl_dec,
      op_xch_a_rpa, op_xch_xa_hl, op_xch_a_mem, op_xch_xa_mem,
      op_xch_a_reg, op_xch_xa_rp, op_rom_table_read_page_offset_form, op_rom_table_read_page_accum_form,
      op_rom_table_read_four_nibble_pointer_form, op_rom_table_read_four_nibble_accum_form
   } op_e;
   typedef enum logic [1:0] {am_hl, am_rpa, am_mem} am_e;
   localparam logic [2:0] R_X = 3'h0;
   localparam logic [2:0] R_A = 3'h1;
   localparam logic [2:0] R_C = 3'h3;
   localparam logic [2:0] R_D = 3'h4;
   localparam logic [2:0] R_E = 3'h5;
   localparam logic [2:0] R_H = 3'h6;
   localparam logic [2:0] R_L = 3'h7;
   localparam logic [1:0] RP_XA = 2'h0;
   localparam logic [1:0] RP_HL = 2'h3;
   localparam logic [3:0] BANK0 = 4'h0;
   localparam logic [3:0] BANK15 = 4'hf;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [3:0] NIB_FULL = 4'hf;
   localparam logic [3:0] REG_RESET = 4'h0;
   localparam logic [1:0] LEN_LONG = 2'h3;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_PTR_STEP = 2'h2;
   localparam logic [1:0] CYC_TABLE = 2'h3;
   localparam logic [1:0] SKIP_SHORT = 2'h1;
   localparam logic [1:0] SKIP_LONG = 2'h2;
   localparam logic [1:0] GRP_NONE = 2'h0;
   localparam logic [1:0] GRP_A = 2'h1;
   localparam logic [1:0] GRP_B = 2'h2;
   // divider terminal counts for the four cpu clock rates
   localparam logic [3:0] DIV_TERM_0 = 4'h0;
   localparam logic [3:0] DIV_TERM_1 = 4'h1;
   localparam logic [3:0] DIV_TERM_2 = 4'h3;
   localparam logic [3:0] DIV_TERM_3 = 4'hf;

   function automatic logic is_step_up(input op_e op);
      return op == op_ld_a_hl_inc || op == op_xch_a_hl_inc;
   endfunction

   function automatic logic is_step_down(input op_e op);
      return op == op_ld_a_hl_dec || op == op_xch_a_hl_dec;
   endfunction

   function automatic logic is_table(input op_e op);
      return op inside {op_rom_table_read_page_offset_form, op_rom_table_read_page_accum_form, op_rom_table_read_four_nibble_pointer_form,
                        op_rom_table_read_four_nibble_accum_form};
   endfunction

   function automatic logic [1:0] grp_of(input op_e op, input logic [1:0] rp);
      if (op == op_mov_a_imm || (op == op_mov_rp_imm && rp == RP_XA)) begin
         return GRP_A;
      end
      if (op == op_mov_rp_imm && rp == RP_HL) begin
         return GRP_B;
      end
      return GRP_NONE;
   endfunction

   function automatic logic [1:0] base_cycles(input op_e op,
                                              input logic [1:0] len);
      if (is_table(op)) begin
         return CYC_TABLE;
      end
      if (is_step_up(op) || is_step_down(op)) begin
         return CYC_PTR_STEP;
      end
      return (len == 2'h0) ? CYC_ONE : len;
   endfunction

   function automatic am_e addr_class(input op_e op);
      if (op == op_ld_a_rpa || op == op_xch_a_rpa) begin
         return am_rpa;
      end
      if (op inside {op_ld_a_mem, op_ld_xa_mem, op_st_mem_a, op_st_mem_xa,
                     op_xch_a_mem, op_xch_xa_mem}) begin
         return am_mem;
      end
      return am_hl;
   endfunction

   function automatic logic writes_ram(input op_e op);
      return op inside {op_st_hl_a, op_st_hl_xa, op_st_mem_a, op_st_mem_xa,
                        op_xch_a_hl, op_xch_a_hl_inc, op_xch_a_hl_dec,
                        op_xch_a_rpa, op_xch_xa_hl, op_xch_a_mem,
                        op_xch_xa_mem};
   endfunction

   function automatic logic is_wide(input op_e op);
      return op inside {op_ld_xa_hl, op_st_hl_xa, op_ld_xa_mem, op_st_mem_xa,
                        op_xch_xa_hl, op_xch_xa_mem};
   endfunction
endpackage

// ==== cycle_tick_gen.sv ====
`timescale 1ns/1ps
module cycle_tick_gen (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [1:0] cpu_clock_divider_control,
   output logic mc_tick
);
   import exec_pkg::*;
   logic [3:0] cnt;
   wire [3:0] term = (cpu_clock_divider_control == 2'h0) ? DIV_TERM_0 :
                     (cpu_clock_divider_control == 2'h1) ? DIV_TERM_1 :
                     (cpu_clock_divider_control == 2'h2) ? DIV_TERM_2 :
                     DIV_TERM_3;

   // one machine cycle per divided cpu clock period [RQ5]
   assign mc_tick = clk_en && cnt == 4'h0;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 4'h0;
      end else if (clk_en) begin
         cnt <= (cnt >= term) ? 4'h0 : cnt + 4'h1;
      end
   end
endmodule

// ==== rom_ram_model.sv ====
`timescale 1ns/1ps
module rom_ram_model (
   input wire logic clock,
   input wire logic ram_we,
   input wire logic ram_wide,
   input wire logic [11:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   input wire logic [11:0] rom_addr,
   output logic [7:0] ram_rdata,
   output logic [7:0] rom_data
);
   logic [3:0] ram [0:4095];
   wire logic [11:0] hi_addr = {ram_addr[11:1], 1'b1};

   // known pattern so the bench can predict every nibble
   initial begin
      for (int i = 0; i < 4096; i++) begin
         ram[i] = 4'(i) ^ 4'(i >> 4) ^ 4'(i >> 8) ^ 4'h9;
      end
   end

   assign ram_rdata = {ram[hi_addr], ram[ram_addr]};
   assign rom_data = rom_addr[7:0] ^ {rom_addr[3:0], rom_addr[11:8]} ^ 8'h3c;

   always @(posedge clock) begin
      if (ram_we) begin
         ram[ram_addr] <= ram_wdata[3:0];
         if (ram_wide) begin
            ram[hi_addr] <= ram_wdata[7:4];
         end
      end
   end
endmodule

// ==== transfer_table_skip_exec_tb_top.sv ====
`timescale 1ns/1ps
module transfer_table_skip_exec_tb_top;
   import exec_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] div = 2'h0;
   logic op_valid = 1'b0;
   op_e op_code = op_other;
   logic [1:0] op_len = 2'h1;
   logic op_table_call = 1'b0;
   logic op_skip_cond = 1'b0;
   logic [1:0] op_rp = 2'h0;
   logic [2:0] op_reg = 3'h0;
   logic [7:0] op_imm = 8'h0;
   logic [11:0] pc = 12'h0;
   logic bse = 1'b0;
   logic [3:0] bnk = 4'h0;
   logic [7:0] ram_rdata, rom_data, ram_wdata, xa, hl, de;
   logic op_ready, op_done, skip_pending, mc_tick, ram_we, ram_wide;
   logic [11:0] ram_addr, rom_addr;
   logic we_seen;
   logic [7:0] xa0;
   int failures = 0;
   int n_compared = 0;
   int tk, ck;

   always #25 clock = ~clock;

   transfer_table_skip_exec uut (.clock(clock), .rst_b(rst_b),
      .clk_en(clk_en), .cpu_clock_divider_control(div),
      .op_valid(op_valid), .op_code(op_code), .op_len(op_len),
      .op_table_call(op_table_call), .op_skip_cond(op_skip_cond),
      .op_reg(op_reg), .op_rp(op_rp), .op_imm(op_imm), .pc(pc),
      .bank_select_enable(bse), .bank_number_register(bnk),
      .ram_rdata(ram_rdata), .rom_data(rom_data), .op_ready(op_ready),
      .op_done(op_done), .skip_pending(skip_pending), .mc_tick(mc_tick),
      .ram_we(ram_we), .ram_wide(ram_wide), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .rom_addr(rom_addr), .wide_accumulator(xa),
      .data_pointer_pair(hl), .table_offset_pair(de));

   rom_ram_model mem (.clock(clock), .ram_we(ram_we), .ram_wide(ram_wide),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .rom_addr(rom_addr),
      .ram_rdata(ram_rdata), .rom_data(rom_data));

   function automatic logic [3:0] ram0(input logic [11:0] a);
      return a[3:0] ^ a[7:4] ^ a[11:8] ^ 4'h9;
   endfunction

   function automatic logic [7:0] romv(input logic [11:0] a);
      return a[7:0] ^ {a[3:0], a[11:8]} ^ 8'h3c;
   endfunction

   task automatic report_and_stop();
      $display("failures=%0d compared=%0d", failures, n_compared);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t value %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t address %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("BAD t=%0t cycles %0d exp %0d", $time, got, exp);
      end
   endtask

   // offer one op, hold it until taken, count ticks and clocks to done
   task automatic run(input op_e c, input logic [1:0] ln,
                      input logic [1:0] rp, input logic [7:0] im,
                      input logic sc, input logic tc);
      int n;
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= c;
      op_len <= ln;
      op_rp <= rp;
      op_imm <= im;
      op_skip_cond <= sc;
      op_table_call <= tc;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (!(mc_tick === 1'b1 && op_ready === 1'b1) && n < 200);
      if (n >= 200) begin
         failures++;
         report_and_stop();
      end
      @(posedge clock);
      op_valid <= 1'b0;
      tk = 0;
      ck = 0;
      we_seen = 1'b0;
      while (n < 400) begin
         @(negedge clock);
         n++;
         ck++;
         if (mc_tick === 1'b1) tk++;
         if (op_done === 1'b1) break;
      end
      if (n >= 400) begin
         failures++;
         report_and_stop();
      end
      we_seen = ram_we;
      @(posedge clock);
      #1;
   endtask

   task automatic t_moves();
      run(op_mov_rp_imm, 2'h2, RP_XA, 8'hc3, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      run(op_mov_rp_imm, 2'h2, 2'h1, 8'h07, 1'b0, 1'b0);
      run(op_mov_a_imm, 2'h1, 2'h0, 8'h05, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      chk_byte(xa, 8'hc5);
      run(op_mov_rp_imm, 2'h2, RP_XA, 8'h77, 1'b0, 1'b0);
      chk_byte(xa, 8'hc5);
      run(op_mov_rp_imm, 2'h2, RP_HL, 8'h3e, 1'b0, 1'b0);
      run(op_mov_rp_imm, 2'h2, RP_HL, 8'h40, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      chk_byte(hl, 8'h3e);
      run(op_mov_rp_imm, 2'h2, 2'h2, 8'h34, 1'b0, 1'b0);
      chk_byte(de, 8'h34);
   endtask

   task automatic t_table();
      @(posedge clock);
      pc <= 12'h5ab;
      run(op_rom_table_read_page_offset_form, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 3);
      chk_addr(rom_addr, 12'h534);
      chk_byte(xa, romv(12'h534));
      xa0 = xa;
      run(op_rom_table_read_page_accum_form, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 3);
      chk_byte(xa, romv({4'h5, xa0}));
      run(op_rom_table_read_four_nibble_pointer_form, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 3);
      chk_byte(xa, romv(12'h734));
      xa0 = xa;
      run(op_rom_table_read_four_nibble_accum_form, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 3);
      chk_addr(rom_addr, {4'h7, xa0});
      chk_byte(xa, romv({4'h7, xa0}));
   endtask

   task automatic t_step();
      @(posedge clock);
      bse <= 1'b1;
      bnk <= 4'h1;
      run(op_ld_a_hl_inc, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      chk_addr(ram_addr, 12'h13e);
      chk_byte({4'h0, xa[3:0]}, {4'h0, ram0(12'h13e)});
      run(op_ld_a_hl_inc, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_byte(hl, 8'h30);
      run(op_mov_rp_imm, 2'h2, 2'h2, 8'h99, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      chk_byte(de, 8'h34);
      run(op_ld_a_hl_dec, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      chk_byte({hl, xa[3:0]}, {8'h3f, ram0(12'h130)});
      run(op_other, 2'h3, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      run(op_xch_a_hl_inc, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      chk_byte({hl, xa[3:0]}, {8'h30, ram0(12'h13f)});
      chk_byte({7'h0, we_seen}, 8'h01);
      chk_byte({4'h0, mem.ram[12'h13f]}, {4'h0, ram0(12'h130)});
      run(op_other, 2'h3, 2'h0, 8'h0, 1'b0, 1'b1);
      chk_cyc(tk, 1);
      run(op_xch_a_hl_dec, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_byte({hl, xa[3:0]}, {8'h3f, ram0(12'h130)});
      chk_byte({4'h0, mem.ram[12'h130]}, {4'h0, ram0(12'h13f)});
      run(op_other, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      run(op_other, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      run(op_other, 2'h1, 2'h0, 8'h0, 1'b1, 1'b0);
      run(op_other, 2'h2, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      chk_byte({7'h0, skip_pending}, 8'h00);
   endtask

   task automatic t_bank();
      run(op_ld_a_rpa, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_addr(ram_addr, 12'h034);
      chk_byte({4'h0, xa[3:0]}, {4'h0, ram0(12'h034)});
      @(posedge clock);
      bse <= 1'b0;
      run(op_ld_a_mem, 2'h2, 2'h0, 8'h90, 1'b0, 1'b0);
      chk_addr(ram_addr, 12'hf90);
      run(op_ld_a_mem, 2'h2, 2'h0, 8'h10, 1'b0, 1'b0);
      chk_addr(ram_addr, 12'h010);
      chk_byte({4'h0, xa[3:0]}, {4'h0, ram0(12'h010)});
      run(op_ld_xa_mem, 2'h2, 2'h0, 8'h10, 1'b0, 1'b0);
      chk_cyc(tk, 2);
      chk_byte(xa, {ram0(12'h011), ram0(12'h010)});
      chk_byte({7'h0, ram_wide}, 8'h01);
   endtask

   // register moves, then an offer held while the clock enable is low
   task automatic t_regs();
      @(posedge clock);
      op_reg <= R_C;
      run(op_xch_a_reg, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      chk_byte(xa, {ram0(12'h011), 4'h7});
      run(op_mov_xa_rp, 2'h2, 2'h1, 8'h0, 1'b0, 1'b0);
      chk_byte(xa, {4'h0, ram0(12'h010)});
      xa0 = xa;
      @(posedge clock);
      clk_en <= 1'b0;
      op_valid <= 1'b1;
      op_code <= op_mov_a_imm;
      op_imm <= 8'h0a;
      repeat (3) @(negedge clock);
      chk_byte({7'h0, mc_tick}, 8'h00);
      @(posedge clock);
      op_valid <= 1'b0;
      clk_en <= 1'b1;
      @(posedge clock);
      #1;
      chk_byte(xa, xa0);
   endtask

   task automatic t_rate();
      @(posedge clock);
      div <= 2'h2;
      run(op_other, 2'h1, 2'h0, 8'h0, 1'b0, 1'b0);
      chk_cyc(tk, 1);
      chk_cyc(ck, 4);
      @(posedge clock);
      div <= 2'h0;
   endtask

   initial begin
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      t_moves();
      t_table();
      t_step();
      t_bank();
      t_regs();
      t_rate();
      report_and_stop();
   end
endmodule
